//--- rtl/bds_command_set.sv
// Read-only battery data command set behind a two-wire serial slave
// Assumes the gauge core feeds measurements on i_clk; serial pins are async
//
// Behaviour
// R01 - 0x0e returns percent of nominal, may exceed 100
// R02 - Percent valid only below 10,400 mAh
// R03 - 0x0f returns remaining mAh, full 16 bits
// R04 - 0x10 returns loaded or learned full capacity
// R05 - 0x11 instant minutes, 65,535 when not discharging
// R06 - 0x12 average minutes, 65,535 marks invalid
// R07 - 0x14 charge current request, gated by messaging
// R08 - 0x15 charge voltage request, gated by messaging
// R09 - Status upper byte holds alarms, two reserved
// R10 - Status lower byte: state bits, error nibble
// R11 - Capacity and time alarms follow measured current
// R12 - Cycle counts once after 15 percent drop
// R13 - Cycle tally steps by one, saturates
// R14 - 0x1b packs day, month, year minus 1980
// R15 - 0x1a returns revision word, normally zero
// R16 - Text replies start with count, max 15
// R17 - 0x23 returns up to 15 data bytes
// R18 - 0x2f high byte second flags, low first
// R19 - 0x3e and 0x3f return empty thresholds
// R20 - 0x18 and 0x19 return nominal values
// R21 - 0x1c returns serial number word
// R22 - Words by read word, strings by block
// R23 - Mode bits 14 and 13 mute charger messages
// R24 - Host writes to these codes are ignored
`include "bds_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module bds_command_set #(
  parameter logic [6:0]  SLAVE_ADDR = 7'h0b,  // Serial slave address
  parameter logic [15:0] SPEC_REV   = 16'h0000 // Arbitrary revision word
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  // Serial pins, asynchronous
  input  wire logic                   i_scc,
  input  wire logic                   i_scd,
  output logic                        o_scd_o,
  output logic                        o_scd_oe,
  // Gauge core values
  input  wire bds_pkg::bds_meas_s     i_meas,
  input  wire bds_pkg::bds_cfg_s      i_cfg,
  input  wire bds_pkg::bds_stat_s     i_stat,
  input  wire logic [7:0]             i_flag_low,
  input  wire logic [7:0]             i_flag_high,
  input  wire logic [15:0]            i_mode,
  input  wire logic                   i_cfg_load,
  input  wire logic                   i_charge_end,
  // Text blocks: count and up to 15 bytes each, code order
  input  wire logic [3:0][4:0]        i_text_len,
  input  wire logic [3:0][14:0][7:0]  i_text,
  // Results
  output logic [15:0]                 o_cycle_tally,
  output logic                        o_charge_msg_en,
  output logic                        o_alarm_msg_en
);

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic rst_s1_q;  // Release stage one
  logic rstn_q;    // Released reset used everywhere
  // Assert at once, release after two edges
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_s1_q <= 1'b0;
      rstn_q   <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rstn_q   <= rst_s1_q;
    end
  end

  logic [1:0] scc_q;    // [0] first stage, [1] second stage
  logic [1:0] scd_q;
  logic       scc_d1_q; // Previous synced clock
  logic       scd_d1_q; // Previous synced data
  // Two stages per pin, then one history stage
  always_ff @(posedge i_clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      scc_q    <= 2'h3;
      scd_q    <= 2'h3;
      scc_d1_q <= 1'b1;
      scd_d1_q <= 1'b1;
    end
    else
    begin
      scc_q    <= {scc_q[0], i_scc};
      scd_q    <= {scd_q[0], i_scd};
      scc_d1_q <= scc_q[1];
      scd_d1_q <= scd_q[1];
    end
  end
  logic scc_rise;  // Clock rising edge
  logic scc_fall;  // Clock falling edge
  logic bus_start; // Data falls, clock high
  logic bus_stop;  // Data rises, clock high
  assign scc_rise  = scc_q[1] & ~scc_d1_q;
  assign scc_fall  = ~scc_q[1] & scc_d1_q;
  assign bus_start = scc_q[1] & scc_d1_q & ~scd_q[1] & scd_d1_q;
  assign bus_stop  = scc_q[1] & scc_d1_q & scd_q[1] & ~scd_d1_q;

  // ---------------------------------------------------------------
  // Cycle tally and charger message enables
  // ---------------------------------------------------------------
  logic [15:0] tally_q;   // Cycles seen
  logic [15:0] base_q;    // Charge level at end of last charge
  logic        armed_q;   // A cycle may still be counted
  // Count once per cycle after the drop; saturate at the top
  always_ff @(posedge i_clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      tally_q <= 16'h0000;
      base_q  <= 16'h0000;
      armed_q <= 1'b0;
    end
    else if (i_cfg_load)
    begin
      tally_q <= i_cfg.cycle_init;  // R13
      armed_q <= 1'b0;
    end
    else if (i_charge_end)
    begin
      base_q  <= i_meas.abs_pct;    // R12
      armed_q <= 1'b1;
    end
    else if (armed_q && base_q >= `BDS_CYCLE_DROP_PCT &&
             i_meas.abs_pct <= base_q - `BDS_CYCLE_DROP_PCT)
    begin
      // Small dips never count, so short top-ups are not cycles
      armed_q <= 1'b0;  // R12
      if (tally_q != `BDS_CYCLE_MAX)
        tally_q <= tally_q + 16'h0001;  // R13
    end
  end

  // Bit 13 mutes everything, bit 14 only the value messages
  always_ff @(posedge i_clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      o_charge_msg_en <= 1'b0;
      o_alarm_msg_en  <= 1'b0;
      o_cycle_tally   <= 16'h0000;
    end
    else
    begin
      o_charge_msg_en <= ~i_mode[`BDS_MODE_NO_VI_MSG] &
                         ~i_mode[`BDS_MODE_NO_ANY_MSG];  // R23 R07 R08
      o_alarm_msg_en  <= ~i_mode[`BDS_MODE_NO_ANY_MSG];  // R23
      o_cycle_tally   <= tally_q;
    end
  end

  // ---------------------------------------------------------------
  // Reply selection, serial engine and pin drive
  // ---------------------------------------------------------------
  bds_pkg::bds_state_e state_q;  // Engine state
  logic [7:0]  cmd_q;     // Latched command code
  logic        cmd_ok_q;  // Command taken in this frame
  logic [7:0]  sh_q;      // Shift register
  logic [3:0]  cnt_q;     // Bits seen in the byte
  logic [4:0]  idx_q;     // Reply byte position
  logic [15:0] snap_q;    // High byte held across the word
  // True for the four text codes
  function automatic logic is_text(input logic [7:0] c);
    is_text = (c >= `BDS_CMD_TEXT_FIRST) && (c <= `BDS_CMD_TEXT_LAST);
  endfunction
  logic        not_dis;    // Not drawing current
  logic        avg_idle;   // Average not a discharge
  logic [15:0] run_eff;    // Instant minutes, masked
  logic [15:0] avg_eff;    // Average minutes, masked
  logic [15:0] status_w;   // Assembled status word
  logic [15:0] word_val;   // Word for the current code
  assign not_dis  = ~i_meas.current[15];
  assign avg_idle = ~i_meas.avg_current[15];
  assign run_eff  = not_dis ? `BDS_INVALID_WORD : i_meas.run_min;   // R05
  assign avg_eff  = avg_idle ? `BDS_INVALID_WORD : i_meas.avg_min;  // R06

  // Alarms use minutes and mAh that already follow the measured current
  assign status_w = {i_stat.over_charge, i_stat.term_charge, 1'b0,
                     i_stat.over_temp, i_stat.term_dis, 1'b0,
                     i_meas.remaining < i_meas.cap_alarm,       // R11
                     avg_eff < i_meas.time_alarm,               // R11 R09
                     i_stat.initialized, ~not_dis,
                     i_stat.fully_chg, i_stat.fully_dis,
                     i_stat.err_code};                          // R10
  // One word per mapped code
  always_comb
  begin
    case (cmd_q)
      `BDS_CMD_ABS_PCT:  word_val = i_meas.abs_pct;          // R01 R02
      `BDS_CMD_REMAIN:   word_val = i_meas.remaining;        // R03
      `BDS_CMD_FULL_CAP: word_val = i_meas.full_cap;         // R04
      `BDS_CMD_RUN_MIN:  word_val = run_eff;                 // R05
      `BDS_CMD_AVG_MIN:  word_val = avg_eff;                 // R06
      `BDS_CMD_CHG_CUR:  word_val = i_meas.chg_cur;          // R07
      `BDS_CMD_CHG_VOLT: word_val = i_meas.chg_volt;         // R08
      `BDS_CMD_STATUS:   word_val = status_w;                // R09 R10
      `BDS_CMD_CYCLES:   word_val = tally_q;                 // R13
      `BDS_CMD_NOM_CAP:  word_val = i_cfg.nom_cap;           // R20
      `BDS_CMD_NOM_VOLT: word_val = i_cfg.nom_volt;          // R20
      `BDS_CMD_SPEC_REV: word_val = SPEC_REV;                // R15
      `BDS_CMD_DATE:     word_val = {i_cfg.year_ofs, i_cfg.month,
                                     i_cfg.day};             // R14
      `BDS_CMD_SERIAL:   word_val = i_cfg.serial;            // R21
      `BDS_CMD_FLAGS:    word_val = {i_flag_high, i_flag_low}; // R18
      `BDS_CMD_EMPTY1:   word_val = i_cfg.empty1_mv;         // R19
      `BDS_CMD_EMPTYF:   word_val = i_cfg.emptyf_mv;         // R19
      default:           word_val = `BDS_INVALID_WORD;
    endcase
  end
  // Byte to send at a given reply position
  logic [1:0] text_sel;   // Which text block
  logic [4:0] text_cnt;   // Clamped count
  logic [7:0] next_byte;  // Byte for position idx_q
  assign text_sel = cmd_q[1:0];
  assign text_cnt = (i_text_len[text_sel] > `BDS_TEXT_MAX) ?
                    `BDS_TEXT_MAX : i_text_len[text_sel];  // R16 R17

  always_comb
  begin
    next_byte = `BDS_NO_BYTE;
    if (is_text(cmd_q))
    begin
      // Block protocol: count first, then characters   R22
      if (idx_q == 5'h00)
        next_byte = {3'h0, text_cnt};                     // R16
      else if (idx_q <= text_cnt)
        next_byte = i_text[text_sel][idx_q - 5'h01];      // R17
    end
    else if (idx_q == 5'h00)
      next_byte = word_val[7:0];                          // R22
    else if (idx_q == 5'h01)
      next_byte = snap_q[15:8];
  end

  // Receive, acknowledge and transmit; writes are taken and dropped
  always_ff @(posedge i_clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      state_q  <= bds_pkg::BDS_IDLE;
      cmd_q    <= 8'h00;
      cmd_ok_q <= 1'b0;
      sh_q     <= 8'h00;
      cnt_q    <= 4'h0;
      idx_q    <= 5'h00;
      snap_q   <= 16'h0000;
    end
    else if (bus_start)
    begin
      // Repeated start keeps the command for the read phase
      state_q <= bds_pkg::BDS_ADDR;
      cnt_q   <= 4'h0;
    end
    else if (bus_stop)
    begin
      state_q  <= bds_pkg::BDS_IDLE;
      cmd_ok_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        bds_pkg::BDS_ADDR, bds_pkg::BDS_CMD, bds_pkg::BDS_WDATA:
        begin
          if (scc_rise)
          begin
            sh_q  <= {sh_q[6:0], scd_q[1]};
            cnt_q <= cnt_q + 4'h1;
          end
          else if (scc_fall && cnt_q == 4'h8)
          begin
            if (state_q == bds_pkg::BDS_ADDR)
              // Reads need a command first in the same frame
              state_q <= (sh_q[7:1] == SLAVE_ADDR &&
                          (!sh_q[0] || cmd_ok_q)) ?
                         bds_pkg::BDS_AACK : bds_pkg::BDS_IDLE;
            else if (state_q == bds_pkg::BDS_CMD)
            begin
              // Unmapped codes are refused with no acknowledge
              state_q  <= (word_hit_code(sh_q)) ?
                          bds_pkg::BDS_CACK : bds_pkg::BDS_IDLE;
              cmd_ok_q <= word_hit_code(sh_q);
              cmd_q    <= sh_q;
            end
            else
              state_q <= bds_pkg::BDS_WACK;  // R24
          end
        end
        bds_pkg::BDS_AACK:
        begin
          if (scc_fall)
          begin
            cnt_q <= 4'h0;
            if (sh_q[0])
            begin
              state_q <= bds_pkg::BDS_RDATA;
              idx_q   <= 5'h01;
              sh_q    <= next_byte;   // Position zero
              snap_q  <= word_val;    // Word read as one snapshot
            end
            else
              state_q <= bds_pkg::BDS_CMD;
          end
          else
            idx_q <= 5'h00;
        end
        bds_pkg::BDS_CACK, bds_pkg::BDS_WACK:
        begin
          // Ack slot ends; data bytes are acknowledged, never stored
          if (scc_fall)
          begin
            state_q <= bds_pkg::BDS_WDATA;  // R24
            cnt_q   <= 4'h0;
          end
        end
        bds_pkg::BDS_RDATA:
        begin
          if (scc_rise)
            cnt_q <= cnt_q + 4'h1;
          else if (scc_fall)
          begin
            if (cnt_q == 4'h8)
              state_q <= bds_pkg::BDS_MACK;
            else
              sh_q <= {sh_q[6:0], 1'b0};
          end
        end
        bds_pkg::BDS_MACK:
        begin
          // Host no-acknowledge ends the reply
          if (scc_rise && scd_q[1])
            state_q <= bds_pkg::BDS_IDLE;
          else if (scc_fall)
          begin
            state_q <= bds_pkg::BDS_RDATA;
            cnt_q   <= 4'h0;
            sh_q    <= next_byte;
            idx_q   <= idx_q + 5'h01;
          end
        end
        default:
          state_q <= bds_pkg::BDS_IDLE;
      endcase
    end
  end

  // Mapped word or text code
  function automatic logic word_hit_code(input logic [7:0] c);
    case (c)
      `BDS_CMD_ABS_PCT, `BDS_CMD_REMAIN, `BDS_CMD_FULL_CAP, `BDS_CMD_RUN_MIN, `BDS_CMD_AVG_MIN,
      `BDS_CMD_CHG_CUR, `BDS_CMD_CHG_VOLT, `BDS_CMD_STATUS, `BDS_CMD_CYCLES, `BDS_CMD_NOM_CAP,
      `BDS_CMD_NOM_VOLT, `BDS_CMD_SPEC_REV, `BDS_CMD_DATE, `BDS_CMD_SERIAL, `BDS_CMD_FLAGS,
      `BDS_CMD_EMPTY1, `BDS_CMD_EMPTYF:
        word_hit_code = 1'b1;
      default:
        word_hit_code = is_text(c);
    endcase
  endfunction

  // Open drain: only ever pull low; change only while clock is low
  always_ff @(posedge i_clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      o_scd_o  <= 1'b0;
      o_scd_oe <= 1'b0;
    end
    else
    begin
      o_scd_o <= 1'b0;
      case (state_q)
        bds_pkg::BDS_AACK, bds_pkg::BDS_CACK, bds_pkg::BDS_WACK: o_scd_oe <= 1'b1;
        bds_pkg::BDS_RDATA: o_scd_oe <= ~sh_q[7];  // R22
        default:            o_scd_oe <= 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- rtl/bds_defines.svh
// Command codes, bit positions and fixed values of the battery data block
// Assumes inclusion by its bare name from the design file
`ifndef BDS_DEFINES_SVH
`define BDS_DEFINES_SVH

// Word command codes
`define BDS_CMD_ABS_PCT     8'h0e
`define BDS_CMD_REMAIN      8'h0f
`define BDS_CMD_FULL_CAP    8'h10
`define BDS_CMD_RUN_MIN     8'h11
`define BDS_CMD_AVG_MIN     8'h12
`define BDS_CMD_CHG_CUR     8'h14
`define BDS_CMD_CHG_VOLT    8'h15
`define BDS_CMD_STATUS      8'h16
`define BDS_CMD_CYCLES      8'h17
`define BDS_CMD_NOM_CAP     8'h18
`define BDS_CMD_NOM_VOLT    8'h19
`define BDS_CMD_SPEC_REV    8'h1a
`define BDS_CMD_DATE        8'h1b
`define BDS_CMD_SERIAL      8'h1c
`define BDS_CMD_FLAGS       8'h2f
`define BDS_CMD_EMPTY1      8'h3e
`define BDS_CMD_EMPTYF      8'h3f
// Block command codes, 0x20 up to 0x23
`define BDS_CMD_TEXT_FIRST  8'h20
`define BDS_CMD_TEXT_LAST   8'h23

// Fixed values
`define BDS_INVALID_WORD    16'hffff
`define BDS_NO_BYTE         8'hff
`define BDS_TEXT_MAX        5'h0f
`define BDS_CYCLE_DROP_PCT  16'h000f
`define BDS_CYCLE_MAX       16'hffff
// Date field positions
`define BDS_DATE_MONTH_LSB  5
`define BDS_DATE_YEAR_LSB   9
// Charger mode bits
`define BDS_MODE_NO_VI_MSG  14
`define BDS_MODE_NO_ANY_MSG 13

`endif

//--- rtl/bds_pkg.sv
// Types shared by the battery data block and its surroundings
// Assumes the gauge core supplies these groups on the device clock
package bds_pkg;

  // Live gauge measurements
  typedef struct packed {
    logic [15:0] abs_pct;      // Percent of nominal capacity
    logic [15:0] remaining;    // mAh left
    logic [15:0] full_cap;     // Learned or loaded full capacity
    logic [15:0] run_min;      // Minutes, from instant current
    logic [15:0] avg_min;      // Minutes, from average current
    logic signed [15:0] current;
    logic signed [15:0] avg_current;
    logic [15:0] chg_cur;      // Requested charge current
    logic [15:0] chg_volt;     // Requested charge voltage
    logic [15:0] cap_alarm;    // Low capacity threshold
    logic [15:0] time_alarm;   // Low time threshold
  } bds_meas_s;

  // Values loaded from configuration memory
  typedef struct packed {
    logic [15:0] nom_cap;
    logic [15:0] nom_volt;
    logic [15:0] serial;
    logic [6:0]  year_ofs;     // Year minus 1980
    logic [3:0]  month;
    logic [4:0]  day;
    logic [15:0] empty1_mv;
    logic [15:0] emptyf_mv;
    logic [15:0] cycle_init;
  } bds_cfg_s;

  // Status conditions owned by the gauge core
  typedef struct packed {
    logic       over_charge;
    logic       term_charge;
    logic       over_temp;
    logic       term_dis;
    logic       initialized;
    logic       fully_chg;
    logic       fully_dis;
    logic [3:0] err_code;
  } bds_stat_s;

  // Serial engine states
  typedef enum logic [8:0] {
    BDS_IDLE  = 9'h001,
    BDS_ADDR  = 9'h002,
    BDS_AACK  = 9'h004,
    BDS_CMD   = 9'h008,
    BDS_CACK  = 9'h010,
    BDS_WDATA = 9'h020,
    BDS_WACK  = 9'h040,
    BDS_RDATA = 9'h080,
    BDS_MACK  = 9'h100
  } bds_state_e;

endpackage

//--- testbench/bds_command_set_sva.sv
// Port checker for the battery data command set
// Assumes one i_clk domain; bound to every bds_command_set instance
`timescale 1ns/1ps
`default_nettype none

module bds_command_set_sva (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_resetn,
  // Link pins and controls
  input wire logic        i_scc,
  input wire logic        i_scd,
  input wire logic        o_scd_o,
  input wire logic        o_scd_oe,
  input wire logic [15:0] i_mode,
  input wire logic        i_cfg_load,
  // Results
  input wire logic [15:0] o_cycle_tally,
  input wire logic        o_charge_msg_en,
  input wire logic        o_alarm_msg_en
);
  // ----------------------------------------
  // Settling after reset, then properties
  // ----------------------------------------
  logic [2:0] age_q;   // Edges since release, saturating
  logic       ok;      // Internal reset copy has let go
  logic       mute_vi; // Either bit mutes value messages

  // Internal reset lags by two flops, so wait four edges
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      age_q <= 3'h0;
    else if (age_q != 3'h4)
      age_q <= age_q + 3'h1;
  end
  assign ok = (age_q == 3'h4);
  assign mute_vi = i_mode[14] | i_mode[13];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!ok);

  sequence s_clk_high;
    i_scc [*3];
  endsequence
  sequence s_stop_seen;
    i_scc && $rose(i_scd);
  endsequence
  property p_open_drain;
    o_scd_o == 1'b0;
  endproperty
  property p_charge_gate;
    o_charge_msg_en == !$past(mute_vi);
  endproperty
  property p_alarm_gate;
    o_alarm_msg_en == !$past(i_mode[13]);
  endproperty
  property p_tally_step;
    $changed(o_cycle_tally) && !$past(i_cfg_load) && !$past(i_cfg_load, 2)
      |-> o_cycle_tally == $past(o_cycle_tally) + 16'h0001;
  endproperty
  property p_tally_hold_max;
    o_cycle_tally == 16'hffff && !i_cfg_load && !$past(i_cfg_load)
      |=> o_cycle_tally == 16'hffff;
  endproperty
  property p_oe_moves_low;
    $changed(o_scd_oe) |-> !$past(i_scc) && !$past(i_scc, 2);
  endproperty
  property p_oe_still_high;
    s_clk_high |=> $stable(o_scd_oe);
  endproperty
  property p_quiet_stop;
    s_stop_seen |-> (!o_scd_oe) [*8];
  endproperty

  a_open_drain: assert property (p_open_drain)
    else $error("pin value not low");
  a_charge_gate: assert property (p_charge_gate)
    else $error("charge enable wrong");
  a_alarm_gate: assert property (p_alarm_gate)
    else $error("alarm enable wrong");
  a_tally_step: assert property (p_tally_step)
    else $error("tally step not one");
  a_tally_hold_max: assert property (p_tally_hold_max)
    else $error("tally left ceiling");
  a_oe_moves_low: assert property (p_oe_moves_low)
    else $error("oe moved, clock high");
  a_oe_still_high: assert property (p_oe_still_high)
    else $error("oe moved in high phase");
  a_quiet_stop: assert property (p_quiet_stop)
    else $error("oe driven after stop");
endmodule

bind bds_command_set bds_command_set_sva u_sva (
  .i_clk, .i_resetn, .i_scc, .i_scd, .o_scd_o, .o_scd_oe,
  .i_mode, .i_cfg_load, .o_cycle_tally, .o_charge_msg_en, .o_alarm_msg_en
);
`default_nettype wire

//--- testbench/bds_host_model.sv
// Host master model for the two-wire link
// Assumes the bench resolves the open-drain line with a pull-up
`timescale 1ns/1ps
`default_nettype none

module bds_host_model #(
  parameter logic [6:0] ADDR = 7'h0b // Device address on the link
) (
  // Clock and link
  input  wire logic i_clk,
  input  wire logic i_scd,
  output logic      o_scc,
  output logic      o_scd_low
);
  logic [7:0] rx [0:17]; // Bytes of the last read
  logic       nak;       // Some address, command or write data byte refused

  // Idle bus: clock stands high, data released
  initial
  begin
    o_scc = 1'b1;
    o_scd_low = 1'b0;
  end

  task automatic q(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // One bit of 200 ns; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    o_scd_low = !b;
    q(3);
    o_scc = 1'b1;
    q(4);
    r = i_scd;
    o_scc = 1'b0;
    q(1);
  endtask

  // Long low phase lets the device release before a repeated start
  task automatic start;
    if (!o_scc)
    begin
      o_scd_low = 1'b0;
      q(7);
      o_scc = 1'b1;
      q(4);
    end
    o_scd_low = 1'b1;
    q(4);
    o_scc = 1'b0;
    q(1);
  endtask

  task automatic stop;
    o_scd_low = 1'b1;
    q(3);
    o_scc = 1'b1;
    q(4);
    o_scd_low = 1'b0;
    q(8);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic last,
                         output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(last, a);
  endtask

  // Word or block read, or a one-byte write, after a command code
  task automatic xfer(input logic [7:0] cmd, input int n, input logic rd,
                      input logic [7:0] wd);
    logic [7:0] junk;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, junk, a0);
    byte_io(cmd, 1'b1, junk, a1);
    if (rd)
    begin
      start();
      byte_io({ADDR, 1'b1}, 1'b1, junk, a2);
      for (int k = 0; k < n; k++)
        byte_io(8'hff, k == n - 1, rx[k], junk[0]);
    end
    else
      byte_io(wd, 1'b1, junk, a2);
    nak = a0 | a1 | a2;
    stop();
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Testbench for the battery data command set
// Assumes the host model drives the link; the line is resolved here
`timescale 1ns/1ps
`default_nettype none

module tb;
  // Clock, reset and link
  logic                  clk = 1'b0;
  logic                  resetn;
  wire logic             scc;
  wire logic             host_low;
  wire logic             scd_line;
  logic                  scd_o;
  logic                  scd_oe;
  // Gauge side
  bds_pkg::bds_meas_s    meas;
  bds_pkg::bds_cfg_s     cfg;
  bds_pkg::bds_stat_s    stat;
  logic [7:0]            flo;
  logic [7:0]            fhi;
  logic [15:0]           mode;
  logic                  cfg_load;
  logic                  charge_end;
  logic [3:0][4:0]       tlen;
  logic [3:0][14:0][7:0] text;
  logic [15:0]           tally;
  logic                  chg_en;
  logic                  alm_en;
  // Bookkeeping
  int                    fail_count = 0;
  int                    cmp_count = 0;
  int                    n;
  logic [7:0]            bad_cmd [5] = '{8'h13, 8'h1d, 8'h24, 8'h30, 8'h40};

  // Pull-up: low while either side pulls
  assign scd_line = !(scd_oe | host_low);
  always #12.5 clk = ~clk;

  bds_command_set #(.SLAVE_ADDR(7'h0b), .SPEC_REV(16'h0000)) dut (
    .i_clk(clk), .i_resetn(resetn), .i_scc(scc), .i_scd(scd_line),
    .o_scd_o(scd_o), .o_scd_oe(scd_oe), .i_meas(meas), .i_cfg(cfg),
    .i_stat(stat), .i_flag_low(flo), .i_flag_high(fhi), .i_mode(mode),
    .i_cfg_load(cfg_load), .i_charge_end(charge_end), .i_text_len(tlen),
    .i_text(text), .o_cycle_tally(tally), .o_charge_msg_en(chg_en),
    .o_alarm_msg_en(alm_en));

  bds_host_model #(.ADDR(7'h0b)) host (
    .i_clk(clk), .i_scd(scd_line), .o_scc(scc), .o_scd_low(host_low));

  task automatic q(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Word read with one extra byte past the word
  task automatic rd_word(input logic [7:0] cmd, input logic [15:0] exp);
    host.xfer(cmd, 3, 1'b1, 8'h00);
    check("ack", 16'(host.nak), 16'h0000);
    check("word", {host.rx[1], host.rx[0]}, exp);
    check("pad", {8'h00, host.rx[2]}, 16'h00ff);
  endtask

  task automatic pulse(input logic ld);
    cfg_load = ld;
    charge_end = !ld;
    q(1);
    cfg_load = 1'b0;
    charge_end = 1'b0;
    q(6);
  endtask

  task automatic complete_run;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    meas = '{16'h0082, 16'h1234, 16'h0fa0, 16'h00c8, 16'h0030, -16'sh01f4,
             -16'sh0064, 16'hffff, 16'h3a98, 16'h2000, 16'h0040};
    cfg = '{16'h1068, 16'h2d00, 16'h5a3c, 7'h13, 4'h6, 5'h15, 16'h2710,
            16'h2328, 16'h0010};
    stat = '1;
    stat.err_code = 4'h5;
    flo = 8'h2c;
    fhi = 8'h91;
    mode = 16'h0000;
    cfg_load = 1'b0;
    charge_end = 1'b0;
    tlen = {5'h14, 5'h00, 5'h03, 5'h0f};
    for (int c = 0; c < 4; c++)
      for (int k = 0; k < 15; k++)
        text[c][k] = 8'h30 + 8'(c * 16 + k);
    q(10);
    resetn = 1'b1;
    q(6);
    rd_word(8'h0e, 16'h0082);
    rd_word(8'h0f, 16'h1234);
    rd_word(8'h10, 16'h0fa0);
    rd_word(8'h11, 16'h00c8);
    rd_word(8'h12, 16'h0030);
    rd_word(8'h14, 16'hffff);
    rd_word(8'h15, 16'h3a98);
    rd_word(8'h16, 16'hdbf5);
    rd_word(8'h18, 16'h1068);
    rd_word(8'h19, 16'h2d00);
    rd_word(8'h1a, 16'h0000);
    rd_word(8'h1b, 16'h0013 * 16'h0200 + 16'h0006 * 16'h0020 + 16'h0015);
    rd_word(8'h1c, 16'h5a3c);
    rd_word(8'h2f, 16'h912c);
    rd_word(8'h3e, 16'h2710);
    rd_word(8'h3f, 16'h2328);
    $display("Test words done");
    // Charging, no alarms: minutes report invalid
    stat = '0;
    meas.remaining = 16'h3000;
    meas.current = 16'sh00c8;
    meas.avg_current = 16'sh0064;
    rd_word(8'h11, 16'hffff);
    rd_word(8'h12, 16'hffff);
    rd_word(8'h16, 16'h0000);
    $display("Test status done");
    for (int m = 0; m < 4; m++)
    begin
      mode = {1'b0, m[1], m[0], 13'h0000};
      q(4);
      check("chg_en", 16'(chg_en), 16'(m == 0));
      check("alm_en", 16'(alm_en), 16'(!m[0]));
    end
    $display("Test modes done");
    for (int c = 0; c < 4; c++)
    begin
      n = (tlen[c] > 5'h0f) ? 15 : int'(tlen[c]);
      host.xfer(8'h20 + 8'(c), 17, 1'b1, 8'h00);
      check("count", {8'h00, host.rx[0]}, 16'(n));
      for (int k = 0; k < 16; k++)
        check("text", {8'h00, host.rx[k + 1]},
              (k < n) ? {8'h00, text[c][k]} : 16'h00ff);
    end
    $display("Test blocks done");
    for (int u = 0; u < 5; u++)
    begin
      host.xfer(bad_cmd[u], 1, 1'b1, 8'h00);
      check("nak", 16'(host.nak), 16'h0001);
    end
    host.xfer(8'h0f, 0, 1'b0, 8'h55);
    check("wr_ack", 16'(host.nak), 16'h0000);
    rd_word(8'h0f, 16'h3000);
    $display("Test refusals done");
    meas.abs_pct = 16'h0032;
    pulse(1'b1);
    check("tally", tally, 16'h0010);
    pulse(1'b0);
    meas.abs_pct = 16'h0024;
    q(6);
    check("tally", tally, 16'h0010);
    meas.abs_pct = 16'h0023;
    q(30);
    check("tally", tally, 16'h0011);
    rd_word(8'h17, 16'h0011);
    cfg.cycle_init = 16'hfffe;
    meas.abs_pct = 16'h0032;
    pulse(1'b1);
    pulse(1'b0);
    meas.abs_pct = 16'h0023;
    q(6);
    check("tally", tally, 16'hffff);
    pulse(1'b0);
    meas.abs_pct = 16'h0014;
    q(6);
    check("tally", tally, 16'hffff);
    $display("Test cycles done");
    complete_run();
  end

  // Watchdog, about three times the expected run
  initial
  begin
    repeat (60000) @(posedge clk);
    check("watchdog", 16'h0001, 16'h0000);
    complete_run();
  end
endmodule
`default_nettype wire
